// [verilog/adc_coding_refdetect_reset.sv]
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
// Notes on behaviour
// [R01] Unipolar results are straight binary codes.
// [R02] Results are 24-bit words scaled by gain.
// [R03] Bipolar results are offset binary, midscale is zero.
// [R04] Burnout source and sink switch together.
// [R05] Excitation sources: magnitude, enable, pin routing.
// [R06] Bias select drives channel one to three.
// [R07] Fast-startup bit raises bias generator current.
// [R08] Reference chosen internal or external, internal stays inside.
// [R09] Reference check only when enabled and external.
// [R10] Low or open reference sets missing flag.
// [R11] Missing reference forces results to all ones.
// [R12] Reference loss in calibration keeps coefficients, flags error.
// [R13] Host checks error flag and all-ones results.
// [R14] Thirty-two ones on serial input reset everything.
// [R15] Same full reset happens at power-up.
// [R16] Host waits 500 us after reset before access.
// [R17] Ones detection also runs in continuous read.
// [R18] Polarity bit chooses unipolar or bipolar coding.
// [R19] A zero bit clears the ones count.
// [R20] Missing flag clears on good reference or disable.
module adc_coding_refdetect_reset (
    // Clock and power-up reset.
    input  wire logic        clk,
    input  wire logic        srst,
    // Register port.
    input  wire logic [2:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [23:0] rdata,
    // Serial pins from the host, asynchronous to clk.
    input  wire logic        sclk,
    input  wire logic        din,
    // Reference comparators, asynchronous to clk.
    input  wire logic        ref_low,
    input  wire logic        ref_open,
    // Converter core, on clk.
    input  wire logic        conv_valid,
    input  wire logic [23:0] conv_code,
    input  wire logic        cal_active,
    input  wire logic        cal_fullscale,
    input  wire logic        cal_done,
    input  wire logic [23:0] cal_coef,
    // Analog controls.
    output logic             burnout_source_en,
    output logic             burnout_sink_en,
    output logic      [1:0]  exc_magnitude,
    output logic             exc_src1_to_b,
    output logic             exc_src2_to_b,
    output logic      [2:0]  bias_channel,
    output logic             bias_fast_startup,
    output logic      [2:0]  ref_select,
    // Status and reset to filter and modulator.
    output logic             missing_reference_flag,
    output logic             cal_error,
    output logic             core_reset
);
    // Control registers.
    logic [7:0]  config_reg;          // Polarity, burnout, bias, reference.
    logic [7:0]  next_config_reg;
    logic [3:0]  io_reg;              // Excitation magnitude and routing.
    logic [3:0]  next_io_reg;
    // Result and coefficient registers.
    logic [23:0] data_reg;            // Last formatted conversion.
    logic [23:0] next_data_reg;
    logic [23:0] coef_ofs;            // Offset coefficient.
    logic [23:0] next_coef_ofs;
    logic [23:0] coef_fs;             // Full-scale coefficient.
    logic [23:0] next_coef_fs;
    logic        next_cal_error;
    logic        cal_ref_lost;        // Reference lost during this calibration.
    logic        next_cal_ref_lost;
    logic [23:0] next_rdata;
    // Reference detect state.
    logic        next_missing;
    logic        check_on;            // Detection is armed.
    logic        ref_low_s;
    logic        ref_open_s;
    // Serial ones counter state.
    logic        sclk_s;
    logic        din_s;
    logic        sclk_prev;           // Last synchronised clock level.
    logic        sclk_rise;
    logic [4:0]  ones;                // Unbroken ones seen so far.
    logic [4:0]  next_ones;
    logic        soft_rst;            // One-cycle reset from the serial input.
    logic        next_soft_rst;
    logic        wipe;                // Either reset source.
    // Derived analog controls.
    logic [2:0]  next_bias_channel;
    logic [2:0]  next_ref_select;
    logic [1:0]  ref_code;
    logic [23:0] coded;

    // Power-up and serial reset return the same registers to defaults.
    assign wipe = srst | soft_rst;  // see [R14] see [R15]

    // Serial clock and data are caught twice before anything looks at them.
    sync2 #(
        .W (2)
    ) u_link_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in ({sclk, din}),
        .sync_out ({sclk_s, din_s})
    );

    // Comparator outputs come from the analog side and are caught likewise.
    sync2 #(
        .W (2)
    ) u_ref_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in ({ref_low, ref_open}),
        .sync_out ({ref_low_s, ref_open_s})
    );

    // The host shifts data in on the rising serial clock edge.
    assign sclk_rise = sclk_s & ~sclk_prev;

    // Counts ones on each rising serial edge, whatever the interface mode is.
    // The count never gates on a read mode, so a host in continuous read
    // must hold the data line low between instructions.
    always_comb begin
        next_ones     = ones;
        next_soft_rst = 1'b0;
        if (sclk_rise) begin
            if (!din_s) begin
                // A zero breaks the run.
                next_ones = '0;  // see [R19]
            end else if (ones == 5'(adc_ctl_pkg::ONES_RESET - 1)) begin
                // The last of the run fires the reset and restarts.
                next_soft_rst = 1'b1;  // see [R14] see [R17]
                next_ones     = '0;
            end else begin
                next_ones = ones + 5'h1;
            end
        end
    end

    // Registers the serial detector; only the power-up reset clears it.
    always_ff @(posedge clk) begin
        if (srst) begin
            sclk_prev <= 1'b0;
            ones      <= '0;
            soft_rst  <= 1'b0;
            core_reset <= 1'b1;
        end else begin
            sclk_prev <= sclk_s;
            ones      <= next_ones;
            soft_rst  <= next_soft_rst;
            // Filter and modulator follow both reset sources.
            core_reset <= next_soft_rst;  // see [R14]
        end
    end

    // Reference code from the two source select bits.
    assign ref_code = {config_reg[adc_ctl_pkg::CFG_REF_HI],
                       config_reg[adc_ctl_pkg::CFG_REF_LO]};

    // Detection is armed only for an external source with the check on.
    assign check_on = config_reg[adc_ctl_pkg::CFG_REFCHK] &
                      (ref_code == adc_ctl_pkg::REF_EXT_A ||
                       ref_code == adc_ctl_pkg::REF_EXT_B);  // see [R09]

    // The flag follows the comparators, so it falls again on its own.
    always_comb begin
        next_missing = check_on & (ref_low_s | ref_open_s);  // see [R10] see [R20]
    end

    // Formats each result; a missing reference clamps it to all ones.
    result_coder #(
        .W (adc_ctl_pkg::RESULT_W)
    ) u_coder (
        .raw        (conv_code),
        .unipolar   (config_reg[adc_ctl_pkg::CFG_UNIPOLAR]),  // see [R18]
        .force_ones (missing_reference_flag),  // see [R11]
        .code       (coded)
    );

    // Bias output is one-hot over channels one to three, none when zero.
    // Reference select is one-hot: external a, external b, internal.
    // The internal reference has no path to the external pins at all.
    always_comb begin
        case ({config_reg[adc_ctl_pkg::CFG_BIAS_HI],
               config_reg[adc_ctl_pkg::CFG_BIAS_LO]})
            2'h1:    next_bias_channel = 3'h1;  // see [R06]
            2'h2:    next_bias_channel = 3'h2;
            2'h3:    next_bias_channel = 3'h4;
            default: next_bias_channel = 3'h0;
        endcase
        case (ref_code)
            adc_ctl_pkg::REF_EXT_A: next_ref_select = 3'h1;  // see [R08]
            adc_ctl_pkg::REF_EXT_B: next_ref_select = 3'h2;
            default:                next_ref_select = 3'h4;
        endcase
    end

    // Register writes, result capture and calibration bookkeeping.
    always_comb begin
        next_config_reg   = config_reg;
        next_io_reg       = io_reg;
        next_data_reg     = data_reg;
        next_coef_ofs     = coef_ofs;
        next_coef_fs      = coef_fs;
        next_cal_error    = cal_error;
        next_cal_ref_lost = 1'b0;
        // Software writes; data and coefficients are read-only, the status error bit only clears.
        if (wr) begin
            case (addr)
                adc_ctl_pkg::REG_CONFIG: next_config_reg = wdata;
                adc_ctl_pkg::REG_IO:     next_io_reg = wdata[3:0];
                adc_ctl_pkg::REG_STATUS: begin
                    // Writing one clears the error flag.
                    if (wdata[adc_ctl_pkg::ST_ERR]) begin
                        next_cal_error = 1'b0;
                    end
                end
                default: begin
                    // Writes elsewhere are dropped.
                end
            endcase
        end
        // Normal conversions land in the data register, full 24 bits.
        if (conv_valid && !cal_active) begin
            next_data_reg = coded;  // see [R01] see [R02] see [R03]
        end
        // Remember any loss of reference while a calibration runs.
        if (cal_active) begin
            next_cal_ref_lost = cal_ref_lost | missing_reference_flag;
        end
        // On completion either keep the old coefficient and flag it, or load.
        // The set comes after the clear so an error is never lost.
        if (cal_done) begin
            if (cal_ref_lost || missing_reference_flag) begin
                next_cal_error = 1'b1;  // see [R12]
            end else if (cal_fullscale) begin
                next_coef_fs = cal_coef;
            end else begin
                next_coef_ofs = cal_coef;
            end
        end
    end

    // Read data stand for exactly one cycle after the read strobe.
    always_comb begin
        next_rdata = '0;
        if (rd) begin
            case (addr)
                adc_ctl_pkg::REG_CONFIG:   next_rdata = {16'h0000, config_reg};
                adc_ctl_pkg::REG_IO:       next_rdata = {20'h00000, io_reg};
                adc_ctl_pkg::REG_STATUS:   next_rdata = {22'h000000, cal_error,
                                                         missing_reference_flag};
                adc_ctl_pkg::REG_DATA:     next_rdata = data_reg;
                adc_ctl_pkg::REG_COEF_OFS: next_rdata = coef_ofs;
                adc_ctl_pkg::REG_COEF_FS:  next_rdata = coef_fs;
                default:                   next_rdata = '0;
            endcase
        end
    end

    // Registers every control, result and derived output.
    always_ff @(posedge clk) begin
        if (wipe) begin
            config_reg   <= adc_ctl_pkg::CONFIG_RESET;  // see [R15]
            io_reg       <= adc_ctl_pkg::IO_RESET;
            data_reg     <= '0;
            coef_ofs     <= adc_ctl_pkg::COEF_OFS_RESET;
            coef_fs      <= adc_ctl_pkg::COEF_FS_RESET;
            cal_error    <= 1'b0;
            cal_ref_lost <= 1'b0;
            rdata        <= '0;
            missing_reference_flag <= 1'b0;
            bias_channel      <= 3'h0;
            ref_select        <= 3'h1;
            burnout_source_en <= 1'b0;
            burnout_sink_en   <= 1'b0;
            bias_fast_startup <= 1'b0;
            exc_magnitude     <= adc_ctl_pkg::EXC_OFF;
            exc_src1_to_b     <= 1'b0;
            exc_src2_to_b     <= 1'b0;
        end else begin
            config_reg   <= next_config_reg;
            io_reg       <= next_io_reg;
            data_reg     <= next_data_reg;
            coef_ofs     <= next_coef_ofs;
            coef_fs      <= next_coef_fs;
            cal_error    <= next_cal_error;
            cal_ref_lost <= next_cal_ref_lost;
            rdata        <= next_rdata;
            missing_reference_flag <= next_missing;
            bias_channel <= next_bias_channel;
            ref_select   <= next_ref_select;
            // One enable bit drives both burnout currents.
            burnout_source_en <= next_config_reg[adc_ctl_pkg::CFG_BURNOUT];  // see [R04]
            burnout_sink_en   <= next_config_reg[adc_ctl_pkg::CFG_BURNOUT];
            // Fast startup simply passes to the bias generator.
            bias_fast_startup <= next_config_reg[adc_ctl_pkg::CFG_BIAS_FAST_STARTUP];  // see [R07]
            // Magnitude zero leaves both sources off.
            exc_magnitude <= next_io_reg[adc_ctl_pkg::IO_MAG_LSB +: 2];  // see [R05]
            // Route: 0 straight, 1 crossed, 2 both on pin a, 3 both on pin b.
            case (next_io_reg[adc_ctl_pkg::IO_ROUTE_LSB +: 2])
                2'h1:    {exc_src1_to_b, exc_src2_to_b} <= 2'h2;
                2'h2:    {exc_src1_to_b, exc_src2_to_b} <= 2'h0;
                2'h3:    {exc_src1_to_b, exc_src2_to_b} <= 2'h3;
                default: {exc_src1_to_b, exc_src2_to_b} <= 2'h1;
            endcase
        end
    end

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // A unipolar result is the raw word unchanged.
    a_unipolar_code: assert property (  // see [R01]
        conv_valid && !cal_active && !wipe && !missing_reference_flag &&
        config_reg[adc_ctl_pkg::CFG_UNIPOLAR] |=> data_reg == $past(conv_code))
        else $error("unipolar result not straight binary");

    // A bipolar result has its top bit flipped.
    a_bipolar_code: assert property (  // see [R03]
        conv_valid && !cal_active && !wipe && !missing_reference_flag &&
        !config_reg[adc_ctl_pkg::CFG_UNIPOLAR]
        |=> data_reg == ($past(conv_code) ^ 24'h800000))
        else $error("bipolar result not offset binary");

    // Missing reference clamps the captured result.
    a_noref_clamp: assert property (  // see [R11]
        conv_valid && !cal_active && !wipe && missing_reference_flag
        |=> data_reg == 24'hFFFFFF)
        else $error("result not forced to all ones");

    // The flag cannot rise while detection is disarmed.
    a_check_gated: assert property (  // see [R09]
        !check_on |=> !missing_reference_flag)
        else $error("missing flag set while check disarmed");

    // An armed check with a low reference sets the flag next cycle.
    a_ref_loss: assert property (  // see [R10]
        check_on && ref_low_s && !soft_rst |=> missing_reference_flag)
        else $error("missing flag not set on low reference");

    // A failed calibration keeps both coefficients and raises the error.
    a_cal_blocked: assert property (  // see [R12]
        cal_done && !wipe && (cal_ref_lost || missing_reference_flag)
        |=> $stable(coef_ofs) && $stable(coef_fs) && cal_error)
        else $error("coefficient loaded despite lost reference");

    // The thirty-second one resets the core and the registers.
    a_ones_reset: assert property (  // see [R14]
        sclk_rise && din_s && ones == 5'h1F
        |=> core_reset ##1 config_reg == adc_ctl_pkg::CONFIG_RESET)
        else $error("serial ones did not reset");

    // A zero on a serial edge empties the count.
    a_zero_clear: assert property (  // see [R19]
        sclk_rise && !din_s |=> ones == 5'h00)
        else $error("ones count survived a zero");

    // Burnout currents never differ.
    a_burnout_pair: assert property (  // see [R04]
        burnout_source_en == burnout_sink_en)
        else $error("burnout source and sink differ");

    // Exactly one reference source, at most one bias channel.
    a_ref_onehot: assert property (  // see [R08] see [R06]
        $onehot(ref_select) && $onehot0(bias_channel))
        else $error("reference or bias select not one-hot");
endmodule

// [verilog/adc_ctl_pkg.sv]
package adc_ctl_pkg;
    // Width of a conversion result and of the calibration coefficients.
    localparam int RESULT_W = 24;
    // Register offsets on the plain register port.
    localparam logic [2:0] REG_CONFIG   = 3'h0;
    localparam logic [2:0] REG_IO       = 3'h1;
    localparam logic [2:0] REG_STATUS   = 3'h2;
    localparam logic [2:0] REG_DATA     = 3'h3;
    localparam logic [2:0] REG_COEF_OFS = 3'h4;
    localparam logic [2:0] REG_COEF_FS  = 3'h5;
    // Configuration register bit positions.
    localparam int CFG_UNIPOLAR = 0;
    localparam int CFG_BURNOUT  = 1;
    localparam int CFG_BIAS_LO  = 2;
    localparam int CFG_BIAS_HI  = 3;
    localparam int CFG_BIAS_FAST_STARTUP    = 4;
    localparam int CFG_REF_LO   = 5;
    localparam int CFG_REF_HI   = 6;
    localparam int CFG_REFCHK   = 7;
    // Excitation register fields: magnitude in [1:0], routing in [3:2].
    localparam int IO_MAG_LSB   = 0;
    localparam int IO_ROUTE_LSB = 2;
    // Status register bit positions.
    localparam int ST_NOREF = 0;
    localparam int ST_ERR   = 1;
    // Reset values.
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [3:0] IO_RESET     = 4'h0;
    localparam logic [23:0] COEF_OFS_RESET = 24'h800000;
    localparam logic [23:0] COEF_FS_RESET  = 24'h500000;
    // Reference source codes; the fourth code also picks the internal one.
    localparam logic [1:0] REF_EXT_A = 2'h0;
    localparam logic [1:0] REF_EXT_B = 2'h1;
    // Excitation magnitude codes: off, 10 uA, 210 uA, 1 mA.
    localparam logic [1:0] EXC_OFF = 2'h0;
    // Number of unbroken ones on the serial input that resets the block.
    localparam int ONES_RESET = 32;
endpackage

// [verilog/sync2.sv]
`timescale 1ns/10ps
// Two flip-flop synchroniser for levels that come from another domain.
module sync2 #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         srst,
    // Level from outside and its safe copy.
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    // First stage; only the second stage reads it.
    logic [W-1:0] meta;

    // Both stages clear on reset so nothing glitches out of it.
    always_ff @(posedge clk) begin
        if (srst) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// [verilog/result_coder.sv]
`timescale 1ns/10ps
// Turns a raw modulator word into the output code the host reads.
module result_coder #(
    parameter int W = 24
) (
    // Raw word: unsigned in unipolar mode, two's complement in bipolar mode.
    input  wire logic [W-1:0] raw,
    input  wire logic         unipolar,
    input  wire logic         force_ones,
    // Formatted result.
    output logic      [W-1:0] code
);
    // Bipolar offset binary is two's complement with its top bit flipped.
    always_comb begin
        code = raw;
        if (!unipolar) begin
            code[W-1] = ~raw[W-1];
        end
        if (force_ones) begin
            code = '1;
        end
    end
endmodule

// [tb/host_link.sv]
`timescale 1ns/10ps
// Host side of the serial link: shifts bits out, one every 200 ns.
module host_link (
    // Serial pins toward the block.
    output logic sclk,
    output logic din
);
    // The clock stands low and data is parked low outside frames.
    initial begin
        sclk = 1'b0;
        din  = 1'b0;
    end
    // Sends n copies of one bit; data settles well before each rising edge.
    task automatic send_bits(input int n, input logic b);
        repeat (n) begin
            din = b;
            #50 sclk = 1'b1;
            #100 sclk = 1'b0;
            #50;
        end
        din = 1'b0;
    endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/10ps
// Self-checking bench for the converter control block.
module tb_top;
    // Short aliases keep the stimulus lines readable.
    localparam logic [2:0] CFG = adc_ctl_pkg::REG_CONFIG;
    localparam logic [2:0] STS = adc_ctl_pkg::REG_STATUS;
    // Host settling time after any reset: 500 us at a 25 ns clock.
    localparam int HOST_WAIT = 20000;
    // Two settling waits plus well under two thousand cycles of tests.
    localparam int TIMEOUT   = 50000;
    // Stimulus toward the block.
    logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic        ref_low = 1'b0, ref_open = 1'b0, conv_valid = 1'b0;
    logic        cal_active = 1'b0, cal_fullscale = 1'b0, cal_done = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00, d = 8'h00;
    logic [3:0]  e = 4'h0;
    logic [23:0] conv_code = 24'h000000, cal_coef = 24'h000000, rdata;
    // Observed outputs.
    logic        sclk, din, bo_src, bo_snk, src1_b, src2_b, fast, noref, err, core_reset;
    logic [1:0]  mag;
    logic [2:0]  bias, refsel;
    // Bookkeeping; expected read data wait in a queue.
    int          bad_count = 0, tests_run = 0, cycles = 0, resets_seen = 0;
    logic [23:0] expq[$];
    logic        rd_seen = 1'b0;

    adc_coding_refdetect_reset adc_coding_refdetect_reset_inst (
        .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sclk(sclk), .din(din), .ref_low(ref_low), .ref_open(ref_open),
        .conv_valid(conv_valid), .conv_code(conv_code), .cal_active(cal_active),
        .cal_fullscale(cal_fullscale), .cal_done(cal_done), .cal_coef(cal_coef),
        .burnout_source_en(bo_src), .burnout_sink_en(bo_snk), .exc_magnitude(mag),
        .exc_src1_to_b(src1_b), .exc_src2_to_b(src2_b), .bias_channel(bias),
        .bias_fast_startup(fast), .ref_select(refsel), .missing_reference_flag(noref),
        .cal_error(err), .core_reset(core_reset));
    host_link host_link_inst (.sclk(sclk), .din(din));

    // Clock at 40 MHz.
    always #12.5 clk = ~clk;

    // Prints the verdict and stops the run.
    task automatic complete_run;
        if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle register write.
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // One-cycle register read; the expectation is queued for the monitor.
    task automatic rd_reg(input logic [2:0] a, input logic [23:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        expq.push_back(exp);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // Hands one raw word to the block, then reads the data register.
    task automatic convert(input logic [23:0] raw, input logic [23:0] exp);
        @(posedge clk);
        conv_code <= raw;
        conv_valid <= 1'b1;
        @(posedge clk);
        conv_valid <= 1'b0;
        rd_reg(adc_ctl_pkg::REG_DATA, exp);
    endtask

    // A short calibration that ends with a new coefficient.
    task automatic calibrate(input logic fs, input logic [23:0] coef);
        @(posedge clk);
        cal_active <= 1'b1;
        cal_fullscale <= fs;
        cal_coef <= coef;
        repeat (3) @(posedge clk);
        cal_done <= 1'b1;
        @(posedge clk);
        cal_done <= 1'b0;
        cal_active <= 1'b0;
    endtask

    // Lets the reference comparators pass the synchronisers, then looks.
    task automatic flag_is(input logic exp);
        repeat (6) @(posedge clk);
        check(24'(noref), 24'(exp));
    endtask

    // Read data stand only in the cycle after the strobe, so look there.
    always @(posedge clk) begin
        if (rd_seen) check(rdata, expq.pop_front());
        rd_seen <= rd;
        if (tests_run > 0 && core_reset === 1'b1) resets_seen++;
        cycles++;
        if (cycles == TIMEOUT) begin
            bad_count++;
            complete_run();
        end
    end

    initial begin
        void'($urandom(94));
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        // The host keeps off the registers while the block settles.
        repeat (HOST_WAIT) @(posedge clk);
        // Power-up defaults.
        rd_reg(CFG, 24'(adc_ctl_pkg::CONFIG_RESET));
        rd_reg(adc_ctl_pkg::REG_COEF_FS, adc_ctl_pkg::COEF_FS_RESET);
        check(24'(refsel), 24'h000001);
        // Random settings; reference check stays off so no flag interferes.
        for (int i = 0; i < 12; i++) begin
            d = 8'($urandom()) & 8'h7F;
            e = 4'($urandom());
            wr_reg(CFG, d);
            wr_reg(adc_ctl_pkg::REG_IO, {4'h0, e});
            repeat (2) @(posedge clk);
            check(24'({bo_src, bo_snk}), 24'({2{d[1]}}));
            check(24'(fast), 24'(d[4]));
            check(24'(bias), (d[3:2] == 2'h0) ? 24'h0 : 24'(1 << (d[3:2] - 1)));
            check(24'(refsel), d[6] ? 24'h4 : (d[5] ? 24'h2 : 24'h1));
            check(24'({mag, src1_b, src2_b}), 24'({e[1:0], e[2], ~(e[3] ^ e[2])}));
            rd_reg(CFG, 24'(d));
        end
        // Unipolar, then bipolar coding at the ends and middle of the range.
        wr_reg(CFG, 8'h01);
        convert(24'h000000, 24'h000000);
        convert(24'hFFFFFF, 24'hFFFFFF);
        convert(24'h800000, 24'h800000);
        wr_reg(CFG, 8'h00);
        convert(24'h800000, 24'h000000);
        convert(24'h000000, 24'h800000);
        convert(24'h7FFFFF, 24'hFFFFFF);
        // An all-ones result sends the host to the flag, which is clear here.
        check(24'(noref), 24'h0);
        // Low reference on external input a with the check on.
        wr_reg(CFG, 8'h81);
        ref_low <= 1'b1;
        flag_is(1'b1);
        convert(24'h123456, 24'hFFFFFF);
        calibrate(1'b1, 24'h654321);
        // The error output settles one edge after the ending strobe.
        @(posedge clk);
        check(24'(err), 24'h1);
        rd_reg(adc_ctl_pkg::REG_COEF_FS, adc_ctl_pkg::COEF_FS_RESET);
        rd_reg(STS, 24'h000003);
        // Internal reference is never checked; input b is.
        wr_reg(CFG, 8'hC1);
        flag_is(1'b0);
        wr_reg(CFG, 8'hA1);
        ref_low <= 1'b0;
        ref_open <= 1'b1;
        flag_is(1'b1);
        ref_open <= 1'b0;
        flag_is(1'b0);
        wr_reg(STS, 8'h02);
        rd_reg(STS, 24'h000000);
        calibrate(1'b0, 24'h0ABCDE);
        @(posedge clk);
        check(24'(err), 24'h0);
        rd_reg(adc_ctl_pkg::REG_COEF_OFS, 24'h0ABCDE);
        // Broken runs of ones must not reset; an unbroken run of 32 must.
        wr_reg(CFG, 8'h12);
        host_link_inst.send_bits(31, 1'b1);
        host_link_inst.send_bits(1, 1'b0);
        host_link_inst.send_bits(31, 1'b1);
        host_link_inst.send_bits(1, 1'b0);
        repeat (10) @(posedge clk);
        check(24'(resets_seen), 24'h0);
        rd_reg(CFG, 24'h000012);
        host_link_inst.send_bits(32, 1'b1);
        repeat (10) @(posedge clk);
        check(24'(resets_seen), 24'h1);
        // A serial reset asks for the same settling time as power-up.
        repeat (HOST_WAIT) @(posedge clk);
        rd_reg(CFG, 24'(adc_ctl_pkg::CONFIG_RESET));
        rd_reg(adc_ctl_pkg::REG_COEF_OFS, adc_ctl_pkg::COEF_OFS_RESET);
        repeat (3) @(posedge clk);
        complete_run();
    end
endmodule
